// file: rtl/acr_ctrl.sv
// Purpose: start decode, busy, and read-out control of the converter
// Assumes: host inputs synchronous to mclk_in
// Notes: result bus is two signals per pin: out and enable
`default_nettype none

module acr_ctrl
(
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // host control lines
    input wire logic chip_en_in,
    input wire logic chip_sel_n_in,
    input wire logic read_conv_in,
    input wire logic byte_addr_short_cycle_in,
    input wire logic width_sel_in,
    // comparator decision
    input wire logic cmp_in,
    // status and data
    output logic busy_out,
    output logic [11:0] result_bus_out,
    output logic [11:0] result_bus_oe_out,
    output logic [11:0] dac_trial_out
);

    acr_pkg::acr_state_t state_reg;
    acr_pkg::acr_state_t state_next;
    logic start_cond;
    logic start_prev_reg;
    logic start_edge;
    logic short_reg;
    logic [11:0] data_reg;
    logic read_cond;
    logic go;
    logic last;
    logic [11:0] trial;
    logic [11:0] word;
    logic [11:0] trial_next;

    // ============================================================
    // start decode: an edge of the combined level catches any input
    // arriving last, and simultaneous changes give a single edge
    assign start_cond = chip_en_in && !chip_sel_n_in && !read_conv_in;
    assign start_edge = start_cond && !start_prev_reg;
    assign read_cond = chip_en_in && !chip_sel_n_in && read_conv_in;
    assign go = (state_reg == acr_pkg::ACR_STEP);
    // trial of the following step: the current decision plus the next bit
    assign trial_next = (cmp_in ? trial : word) | ((trial ^ word) >> 1);

    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
            start_prev_reg <= 1'b1;
        else
            start_prev_reg <= start_cond;
    end

    // ============================================================
    // length select latched on every start edge, busy or not
    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
            short_reg <= 1'b0;
        else if (start_edge)
            short_reg <= byte_addr_short_cycle_in;
    end

    // ============================================================
    // conversion sequence
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            acr_pkg::ACR_IDLE:
                if (start_edge)
                    state_next = acr_pkg::ACR_STEP;
            acr_pkg::ACR_STEP:
                if (last)
                    state_next = acr_pkg::ACR_LATCH;
            acr_pkg::ACR_LATCH:
                state_next = acr_pkg::ACR_IDLE;
            default:
                state_next = acr_pkg::ACR_IDLE;
        endcase
    end

    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
            state_reg <= acr_pkg::ACR_IDLE;
        else
            state_reg <= state_next;
    end

    acr_sar u_sar
    (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .go_in(go),
        .short_in(short_reg),
        .cmp_in(cmp_in),
        .trial_out(trial),
        .word_out(word),
        .last_out(last)
    );

    // ============================================================
    // output data register, loaded at the same edge at which busy drops
    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
            data_reg <= acr_pkg::RESULT_RST;
        else if (state_reg == acr_pkg::ACR_LATCH)
            data_reg <= word;
    end

    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            busy_out <= 1'b0;
            dac_trial_out <= acr_pkg::RESULT_RST;
        end
        else
        begin
            busy_out <= (state_next != acr_pkg::ACR_IDLE);
            // registered trial leads the sar by one step, so the comparator
            // answers for the bit that the sar decides at the next edge
            if (state_next != acr_pkg::ACR_STEP)
                dac_trial_out <= acr_pkg::RESULT_RST;
            else if (go)
                dac_trial_out <= trial_next;
            else
                dac_trial_out <= trial;
        end
    end

    // ============================================================
    // read-out: full word or two left-justified bytes
    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            result_bus_out <= acr_pkg::RESULT_RST;
            result_bus_oe_out <= 12'h000;
        end
        else if (!read_cond || state_next != acr_pkg::ACR_IDLE ||
                 state_reg != acr_pkg::ACR_IDLE)
        begin
            result_bus_out <= acr_pkg::RESULT_RST;
            result_bus_oe_out <= 12'h000;
        end
        else if (width_sel_in)
        begin
            result_bus_out <= data_reg;
            result_bus_oe_out <= 12'hFFF;
        end
        else if (!byte_addr_short_cycle_in)
        begin
            result_bus_out <= {4'h0, data_reg[11:4]};
            result_bus_oe_out <= 12'h0FF;
        end
        else
        begin
            result_bus_out <= {4'h0, data_reg[3:0], 4'h0};
            result_bus_oe_out <= 12'h0FF;
        end
    end

    // ============================================================
    // checks
    sequence s_start;
        start_edge && !busy_out;
    endsequence

    sequence s_done;
        busy_out ##1 !busy_out;
    endsequence

    a_busy_rises: assert property (@(posedge mclk_in) disable iff (rst_in)
        s_start |=> busy_out)
        else $error("busy did not rise after start");
    a_busy_floats: assert property (@(posedge mclk_in) disable iff (rst_in)
        busy_out |-> result_bus_oe_out == 12'h000)
        else $error("outputs driven while busy");
    a_short_len: assert property (@(posedge mclk_in) disable iff (rst_in)
        (s_start and (byte_addr_short_cycle_in == 1'b1)) ##1
        short_reg [*8] |-> busy_out ##1 busy_out ##1 !busy_out)
        else $error("short conversion length wrong");
    a_long_len: assert property (@(posedge mclk_in) disable iff (rst_in)
        (s_start and (byte_addr_short_cycle_in == 1'b0)) ##1
        (short_reg == 1'b0) [*8] ##1 (short_reg == 1'b0) [*4] |->
        busy_out ##1 busy_out ##1 !busy_out)
        else $error("long conversion length wrong");
    a_no_restart: assert property (@(posedge mclk_in) disable iff (rst_in)
        busy_out && start_edge |=> dac_trial_out != acr_pkg::MID_CODE)
        else $error("conversion restarted while busy");
    a_data_latch: assert property (@(posedge mclk_in) disable iff (rst_in)
        s_done |-> data_reg == $past(word))
        else $error("busy fell before data latched");
    a_no_read: assert property (@(posedge mclk_in) disable iff (rst_in)
        !$past(read_cond) |-> result_bus_oe_out == 12'h000)
        else $error("outputs driven without read");
    a_low_byte: assert property (@(posedge mclk_in) disable iff (rst_in)
        result_bus_oe_out == 12'h0FF && $past(byte_addr_short_cycle_in) |->
        result_bus_out[3:0] == 4'h0)
        else $error("low byte trailing zeros missing");

endmodule // acr_ctrl

`default_nettype wire

// file: rtl/acr_pkg.sv
// Purpose: constants for the converter start and read control block
// Assumes: 250 MHz clock, inputs synchronous to it
// Notes: fields and timing shared by the control and the sequencer
//
// Notes on behaviour
// - start on last qualifying input to arrive
// - simultaneous qualifying changes start one conversion
// - busy high exactly while converting
// - data outputs high-impedance throughout conversion
// - start edges do not restart the sequencer while busy
// - start edge while busy relatches length select
// - chip enable high needed; rising edge starts
// - chip select low needed; falling edge starts
// - read/convert low converts, high reads
// - byte address one eight bits, zero twelve
// - width select high drives all twelve bits
// - byte mode: msb byte, or lsbs plus zeros
// - outputs enabled only on full read condition
// - result is straight binary, msb first
// - eight-bit conversion leaves four lsbs zero
// - only byte address latched; others live
// - outputs float until all read conditions hold
// - busy falls at the same edge that latches the result
`default_nettype none

package acr_pkg;

    // ============================================================
    // data layout
    localparam int RES_W = 12;
    localparam int BYTE_W = 8;
    localparam int LOW_NIB_W = 4;
    localparam logic [11:0] RESULT_RST = 12'h000;
    localparam logic [11:0] MID_CODE = 12'h800;
    localparam logic [11:0] FULL_CODE = 12'hFFF;

    // ============================================================
    // conversion lengths, in steps
    localparam logic [3:0] STEPS_LONG = 4'hC;
    localparam logic [3:0] STEPS_SHORT = 4'h8;

    // ============================================================
    // host setup time, informational for the partner
    localparam int HOST_SETUP_NS = 50;
    localparam int CLK_PERIOD_NS = 4;
    localparam int HOST_SETUP_CYC =
        (HOST_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        ACR_IDLE,
        ACR_STEP,
        ACR_LATCH
    } acr_state_t;

endpackage

`default_nettype wire

// file: rtl/acr_sar.sv
// Purpose: successive approximation register, one bit per step
// Assumes: comparator input is synchronous, high means keep trial bit
// Notes: number of steps chosen at each step from the live length
`default_nettype none

module acr_sar
(
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // control
    input wire logic go_in,
    input wire logic short_in,
    input wire logic cmp_in,
    // results
    output logic [11:0] trial_out,
    output logic [11:0] word_out,
    output logic last_out
);

    logic [3:0] step_reg;
    logic [11:0] bits_reg;
    logic [3:0] limit;
    logic [3:0] pos;

    assign limit = short_in ? acr_pkg::STEPS_SHORT : acr_pkg::STEPS_LONG;
    assign pos = 4'hB - step_reg;
    assign last_out = go_in && (step_reg + 4'h1 >= limit);
    assign trial_out = bits_reg | (12'h001 << pos);
    assign word_out = bits_reg;

    // ============================================================
    // msb first, one decision per clock
    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            step_reg <= 4'h0;
            bits_reg <= acr_pkg::RESULT_RST;
        end
        else if (!go_in)
        begin
            step_reg <= 4'h0;
            bits_reg <= acr_pkg::RESULT_RST;
        end
        else
        begin
            step_reg <= step_reg + 4'h1;
            if (cmp_in)
                bits_reg <= trial_out;
        end
    end

endmodule // acr_sar

`default_nettype wire

// file: verif/acr_cmp_model.sv
// Purpose: comparator stand-in for the analog array of the converter
// Assumes: target_in holds the sampled input as a straight binary code
// Notes: keeps the trial bit while the trial does not exceed the target
`default_nettype none

module acr_cmp_model
(
    // trial word and held sample
    input wire logic [11:0] trial_in,
    input wire logic [11:0] target_in,
    // decision
    output logic cmp_out
);
    timeunit 1ns;
    timeprecision 1ps;

    assign cmp_out = (trial_in <= target_in);
endmodule // acr_cmp_model

`default_nettype wire

// file: verif/tb_acr_ctrl.sv
// Purpose: self-checking bench for the start and read control
// Assumes: comparator model stands in for the analog array
// Notes: reads are queued by the driver and compared by a monitor
`default_nettype none

module tb_acr_ctrl;
    timeunit 1ns;
    timeprecision 1ps;

    logic mclk_in = 1'b0;
    logic rst_in = 1'b1;
    logic ce = 1'b0;
    logic cs_n = 1'b1;
    logic rc = 1'b1;
    logic addr = 1'b0;
    logic wsel = 1'b0;
    logic chk = 1'b0;
    logic [11:0] tgt = 12'h000;
    logic cmp;
    logic busy;
    logic [11:0] dq;
    logic [11:0] oe;
    logic [11:0] trial;
    logic [23:0] q[$];
    logic [11:0] edge_v [4] = '{12'h000, 12'h7FF, 12'h800, 12'hFFF};
    int errors = 0;
    int n_compared = 0;
    int seed = 32'hcd76c3c4;

    initial forever #2 mclk_in = ~mclk_in;

    acr_ctrl u_dut
    (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .chip_en_in(ce),
        .chip_sel_n_in(cs_n),
        .read_conv_in(rc),
        .byte_addr_short_cycle_in(addr),
        .width_sel_in(wsel),
        .cmp_in(cmp),
        .busy_out(busy),
        .result_bus_out(dq),
        .result_bus_oe_out(oe),
        .dac_trial_out(trial)
    );

    acr_cmp_model u_cmp
    (
        .trial_in(trial),
        .target_in(tgt),
        .cmp_out(cmp)
    );

    // ============================================================
    // compare and report
    task automatic cmp_v(input logic [23:0] got, input logic [23:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    always @(negedge mclk_in)
    begin
        if (chk === 1'b1)
            cmp_v({oe, dq}, q.pop_front());
    end

    // ============================================================
    // host cycles, all driven at the falling edge
    task automatic rd(input logic e, input logic w, input logic a,
                      input logic [11:0] r);
        logic [23:0] x;
        x = w ? {12'hFFF, r} : {12'h0FF, 4'h0, r[11:4]};
        if (!w && a)
            x = {12'h0FF, 4'h0, r[3:0], 4'h0};
        if (!e)
            x = 24'h000000;
        ce = e;
        cs_n = 1'b0;
        rc = 1'b1;
        wsel = w;
        addr = a;
        @(negedge mclk_in);
        q.push_back(x);
        chk <= 1'b1;
        @(negedge mclk_in);
        chk <= 1'b0;
    endtask

    task automatic conv(input int how, input logic s, input logic [11:0] t);
        int n;
        logic [23:0] steps;
        steps = s ? 24'(acr_pkg::STEPS_SHORT) : 24'(acr_pkg::STEPS_LONG);
        tgt = t;
        addr = s;
        ce = (how == 0 || how == 2);
        cs_n = (how >= 2);
        rc = (how == 0 || how == 3);
        repeat (acr_pkg::HOST_SETUP_CYC) @(negedge mclk_in);
        ce = 1'b1;
        cs_n = 1'b0;
        rc = 1'b0;
        n = 0;
        @(negedge mclk_in);
        while (busy === 1'b1 && n < 40)
        begin
            cmp_v({oe, 12'h000}, 24'h000000);
            rc = (n == 2 || n == 3 || n >= 6);
            n++;
            @(negedge mclk_in);
        end
        cmp_v({oe, dq}, 24'h000000);
        cmp_v(24'(n), steps + 24'h1);
        if (n >= 40)
        begin
            errors++;
            close_out();
        end
    endtask

    // ============================================================
    // main sequence
    initial
    begin
        logic [11:0] r;
        logic [11:0] t;
        logic s;
        repeat (8) @(negedge mclk_in);
        rst_in = 1'b0;
        @(negedge mclk_in);
        rd(1'b0, 1'b1, 1'b0, 12'h000);
        for (int i = 0; i < 8; i++)
        begin
            t = (i < 4) ? edge_v[i] : 12'($random(seed));
            s = (i >= 4);
            r = s ? {t[11:4], 4'h0} : t;
            conv(i % 4, s, t);
            rd(1'b1, 1'b1, 1'b1, r);
            rd(1'b1, 1'b0, 1'b0, r);
            rd(1'b1, 1'b0, 1'b1, r);
            rd(1'b0, 1'b1, 1'b0, r);
            $display("test %0d done", i);
        end
        close_out();
    end
endmodule // tb_acr_ctrl

`default_nettype wire
